// File: rtl/mlcd_top.sv
// meter mode select, counter, peak hold and triplex lcd drive
//
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module mlcd_top
   import mlcd_pkg::*;
#(
   parameter int OSC_DIV_P  = OSC_DIV,
   parameter int GATE_DIV_P = GATE_DIV,
   parameter int CONV_P     = CONV_TICKS,
   parameter int INTEG_P    = INTEG_TICKS
) (
   input  wire logic            i_clk,
   input  wire logic            i_reset_n,
   input  wire logic            i_measure_select,
   input  wire logic            i_probe_mode_select,
   input  wire logic            i_range_or_pulse_input,
   input  wire logic            i_low_probe_input,
   input  wire logic            i_high_probe_input,
   input  wire logic            i_peak_hold_select,
   input  wire logic            i_low_battery,
   input  wire logic [CW-1:0]   i_conv_data,
   input  wire logic [3:0]      i_avs_address,
   input  wire logic            i_avs_read,
   input  wire logic            i_avs_write,
   input  wire logic [31:0]     i_avs_writedata,
   input  wire logic [3:0]      i_avs_byteenable,
   output logic [31:0]          o_avs_readdata,
   output logic                 o_avs_waitrequest,
   output logic [1:0]           o_backplane_first,
   output logic [1:0]           o_backplane_second,
   output logic [1:0]           o_backplane_third,
   output logic [2*LINES-1:0]   o_segment_level,
   output logic                 o_annunciator,
   output logic                 o_buzzer,
   output logic                 o_conv_clk,
   output logic                 o_integrate_phase
);
   // ********************************
   // input synchronisers
   // ********************************
   localparam int NS = 7;
   logic [NS-1:0] pin_raw;
   logic [NS-1:0] sync1_q;
   logic [NS-1:0] sync2_q;
   logic          pulse_prev_q;
   assign pin_raw = {i_low_battery, i_peak_hold_select, i_high_probe_input,
                     i_low_probe_input, i_range_or_pulse_input,
                     i_probe_mode_select, i_measure_select};

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sync1_q      <= '0;
         sync2_q      <= '0;
         pulse_prev_q <= 1'b0;
      end else begin
         sync1_q      <= pin_raw;
         sync2_q      <= sync1_q;
         pulse_prev_q <= sync2_q[2];
      end
   end

   logic meas_s, probe_s, pulse_s, lo_s, hi_s, peak_s, bat_s;
   assign {bat_s, peak_s, hi_s, lo_s, pulse_s, probe_s, meas_s} = sync2_q;

   logic freq_mode, volt_mode, pulse_edge;
   assign freq_mode  = meas_s && !probe_s;
   assign volt_mode  = !meas_s && !probe_s;
   assign pulse_edge = pulse_s && !pulse_prev_q;

   // ********************************
   // time base
   // ********************************
   logic osc_tick, gate_tick, slot_tick, tone_tick;
   mlcd_divider #(.DIV(OSC_DIV_P)) u_osc (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_step(1'b1), .o_tick(osc_tick));
   mlcd_divider #(.DIV(GATE_DIV_P)) u_gate (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_step(osc_tick),
      .o_tick(gate_tick));
   mlcd_divider #(.DIV(SLOT_DIV)) u_slot (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_step(osc_tick),
      .o_tick(slot_tick));
   mlcd_divider #(.DIV(TONE_DIV / 2)) u_tone (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_step(osc_tick),
      .o_tick(tone_tick));

   logic tone_q;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tone_q     <= 1'b0;
         o_conv_clk <= 1'b0;
      end else begin
         if (tone_tick) tone_q <= !tone_q;
         if (osc_tick) o_conv_clk <= !o_conv_clk;
      end
   end

   // ********************************
   // conversion cycle
   // ********************************
   localparam int VW = $clog2(CONV_P);
   logic [VW-1:0] conv_cnt_q;
   logic          conv_end;
   assign conv_end = osc_tick && (conv_cnt_q == VW'(CONV_P - 1));

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         conv_cnt_q        <= '0;
         o_integrate_phase <= 1'b0;
      end else begin
         if (osc_tick) conv_cnt_q <= conv_end ? '0 : conv_cnt_q + VW'(1);
         o_integrate_phase <= (conv_cnt_q < VW'(INTEG_P));
      end
   end

   // ********************************
   // frequency counter
   // ********************************
   logic [RW-1:0] pulse_cnt_q;
   logic [RW-1:0] freq_val;
   assign freq_val = pulse_cnt_q + RW'(pulse_edge);

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pulse_cnt_q <= '0;
      end else if (gate_tick || !freq_mode) begin
         pulse_cnt_q <= '0;
      end else if (pulse_edge) begin
         pulse_cnt_q <= pulse_cnt_q + RW'(1);
      end
   end

   // ********************************
   // result and peak hold
   // ********************************
   logic          new_valid;
   logic [RW-1:0] new_val;
   logic [RW-1:0] reading_q;
   assign new_valid = (freq_mode && gate_tick) || (volt_mode && conv_end);
   assign new_val   = freq_mode ? freq_val : RW'(i_conv_data);

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         reading_q <= '0;
      end else if (new_valid && (!peak_s || new_val > reading_q)) begin
         reading_q <= new_val;
      end
   end

   // ********************************
   // register file over avalon-mm
   // ********************************
   logic        ack_q;
   logic [31:0] ctrl_q;
   logic [31:0] seg_q;
   logic [31:0] status;
   logic        over;
   assign over = (reading_q > FULL_SCALE) && !probe_s;
   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
   assign status = {24'h0, bat_s, o_integrate_phase, hi_s && probe_s,
                    lo_s && probe_s, over, peak_s, probe_s, freq_mode};

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ack_q          <= 1'b0;
         o_avs_readdata <= '0;
      end else begin
         ack_q <= (i_avs_read || i_avs_write) && !ack_q;
         if (i_avs_read && !ack_q) begin
            unique case (i_avs_address)
               REG_CTRL:    o_avs_readdata <= ctrl_q;
               REG_SEG:     o_avs_readdata <= seg_q;
               REG_READING: o_avs_readdata <= 32'(reading_q);
               REG_STATUS:  o_avs_readdata <= status;
               default:     o_avs_readdata <= '0;
            endcase
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctrl_q <= CTRL_RESET;
         seg_q  <= SEG_RESET;
      end else if (i_avs_write && ack_q) begin
         for (int i = 0; i < 4; i++) begin
            if (i_avs_byteenable[i]) begin
               if (i_avs_address == REG_CTRL && i == 0)
                  ctrl_q[CTRL_SIGN_BIT] <= i_avs_writedata[CTRL_SIGN_BIT];
               if (i_avs_address == REG_SEG)
                  seg_q[8*i +: 8] <= i_avs_writedata[8*i +: 8];
            end
         end
      end
   end

   // ********************************
   // multiplex phase
   // ********************************
   logic [1:0] slot_q;
   logic       pos_q;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         slot_q <= 2'h0;
         pos_q  <= 1'b1;
      end else if (slot_tick) begin
         slot_q <= (slot_q == 2'h2) ? 2'h0 : slot_q + 2'h1;
         if (slot_q == 2'h2) pos_q <= !pos_q;
      end
   end

   // ********************************
   // segment map and annunciators
   // ********************************
   // seg_q byte k holds digit k segments a..g in bits 0..6
   logic [DIGITS-1:0] dp_on;
   logic [3:0]        ann;
   logic              hi_ann, lo_ann;
   logic [3*LINES-1:0] seg_state;
   assign hi_ann = probe_s && hi_s;
   assign lo_ann = probe_s && lo_s;
   assign ann    = {hi_ann, over, peak_s, 1'b0};
   // decimal selects pick a point only outside probe mode
   assign dp_on  = probe_s ? '0 : (4'h1 << {hi_s, lo_s}) & 4'h7;

   genvar d;
   generate
      for (d = 0; d < DIGITS; d++) begin : g_dig
         // bit order within a line is backplane one, two, three
         assign seg_state[9*d +: 3]     = {dp_on[d], seg_q[8*d+5],
                                           seg_q[8*d+0]};
         assign seg_state[9*d+3 +: 3]   = {seg_q[8*d+4], seg_q[8*d+6],
                                           seg_q[8*d+1]};
         assign seg_state[9*d+6 +: 3]   = {seg_q[8*d+3], seg_q[8*d+2],
                                           ann[d]};
      end
   endgenerate
   assign seg_state[3*LINES-1 -: 3] = {bat_s, ctrl_q[CTRL_SIGN_BIT],
                                       lo_ann};

   logic [5:0] bp_lvl;
   mlcd_seg_drive #(.N(LINES)) u_drive (
      .i_clk    (i_clk),
      .i_reset_n(i_reset_n),
      .i_slot   (slot_q),
      .i_pos    (pos_q),
      .i_seg    (seg_state),
      .o_bp     (bp_lvl),
      .o_line   (o_segment_level)
   );
   assign o_backplane_first  = bp_lvl[1:0];
   assign o_backplane_second = bp_lvl[3:2];
   assign o_backplane_third  = bp_lvl[5:4];

   // ********************************
   // annunciator square wave and buzzer
   // ********************************
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_annunciator <= 1'b0;
         o_buzzer      <= 1'b0;
      end else begin
         o_annunciator <= !pos_q;
         o_buzzer      <= probe_s && lo_s && tone_q;
      end
   end

   // ********************************
   // assertions
   // ********************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   property p_freq_clear;
      freq_mode && gate_tick |=> pulse_cnt_q == '0;
   endproperty
   a_freq_clear: assert property (p_freq_clear)
      else $error("pulse counter not cleared at gate end");

   property p_freq_xfer;
      freq_mode && gate_tick && !peak_s |=> reading_q == $past(freq_val);
   endproperty
   a_freq_xfer: assert property (p_freq_xfer)
      else $error("count not moved to reading at gate end");

   property p_gate_spacing;
      gate_tick |=> !gate_tick [*8];
   endproperty
   a_gate_spacing: assert property (p_gate_spacing)
      else $error("gate ticks too close");

   property p_peak_mono;
      peak_s && $past(peak_s) |-> reading_q >= $past(reading_q);
   endproperty
   a_peak_mono: assert property (p_peak_mono)
      else $error("held peak decreased");

   // checked at the pins while the first backplane is selected at V3
   property p_probe_ann;
      o_backplane_first == LVL_V3 |->
         ((o_segment_level[2*LINES-1 -: 2] == LVL_V0) == $past(lo_ann)) &&
         ((o_segment_level[2*LINES-3 -: 2] == LVL_V0) == $past(hi_ann));
   endproperty
   a_probe_ann: assert property (p_probe_ann)
      else $error("probe annunciator does not follow input");

   property p_buzz_off;
      !(probe_s && lo_s) |=> !o_buzzer;
   endproperty
   a_buzz_off: assert property (p_buzz_off)
      else $error("buzzer on without low probe level");

   property p_slot_range;
      slot_q != 2'h3;
   endproperty
   a_slot_range: assert property (p_slot_range)
      else $error("multiplex phase out of range");

   property p_ann_edge;
      $changed(o_annunciator) |-> $past(slot_q, 2) == 2'h2;
   endproperty
   a_ann_edge: assert property (p_ann_edge)
      else $error("annunciator toggled mid frame");

   property p_avs_wait;
      (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
   endproperty
   a_avs_wait: assert property (p_avs_wait)
      else $error("waitrequest held longer than one cycle");

   c_freq: cover property (freq_mode && gate_tick && pulse_cnt_q != '0);
   c_peak: cover property (peak_s && new_valid && new_val > reading_q);
   c_buzz: cover property (o_buzzer);
endmodule : mlcd_top
`default_nettype wire

// File: rtl/mlcd_pkg.sv
// constants for the meter mode and triplex lcd drive block
//
// Overview of operation
// - measure select high, probe select low: count pulses on range/pulse input
// - counter gate is oscillator divided by 40,000, one second at 40 kHz
// - probe select high turns decimal-point selects into low/high probe inputs
// - in probe mode each high probe input lights its own annunciator
// - in probe mode the buzzer runs whenever the low probe input is high
// - probe inputs are neither latched nor stretched; outputs follow levels
// - peak hold high keeps the largest result, updating only when larger
// - conversion cycle is 400 ms; peak counts only if present at the end of the cycle
// - lcd multiplexed three to one over three shared backplanes
// - backplane frequency is the oscillator divided by 240
// - backplane waveforms are fixed and independent of displayed content
// - segment line level per phase comes from its segment state on the selected backplane
// - lines carry a,b / f,g,c / e,d,dp on backplanes one, two, three
// - decimal points, sign and five annunciators each driven by their condition
// - annunciator output is a square wave at the backplane frequency
// - oscillator divided by two for converter clock, by eight for buzzer tone
package mlcd_pkg;
   // ********************************
   // timing
   // ********************************
   localparam int CLK_HZ        = 20_000_000;
   localparam int OSC_HZ        = 40_000;
   localparam int OSC_DIV       = CLK_HZ / OSC_HZ;
   localparam int GATE_DIV      = 40_000;
   localparam int BP_DIV        = 240;
   localparam int BP_SLOTS      = 6;
   localparam int SLOT_DIV      = BP_DIV / BP_SLOTS;
   localparam int CONV_CLK_DIV  = 2;
   localparam int TONE_DIV      = 8;
   localparam int CONV_TIME_MS  = 400;
   localparam int CONV_TICKS    = OSC_HZ / 1000 * CONV_TIME_MS;
   localparam int INTEG_TICKS   = CONV_TICKS / 4;
   // ********************************
   // data widths and limits
   // ********************************
   localparam int RW            = 23;
   localparam int CW            = 12;
   localparam int DIGITS        = 4;
   localparam int LINES         = 3 * DIGITS + 1;
   localparam logic [RW-1:0] FULL_SCALE = 23'h000f9f;
   // ********************************
   // register map, byte offsets
   // ********************************
   localparam logic [3:0] REG_CTRL    = 4'h0;
   localparam logic [3:0] REG_SEG     = 4'h4;
   localparam logic [3:0] REG_READING = 4'h8;
   localparam logic [3:0] REG_STATUS  = 4'hc;
   localparam int CTRL_SIGN_BIT       = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] SEG_RESET  = 32'h0000_0000;
   // status bits
   localparam int ST_FREQ  = 0;
   localparam int ST_PROBE = 1;
   localparam int ST_PEAK  = 2;
   localparam int ST_OVER  = 3;
   localparam int ST_LOW   = 4;
   localparam int ST_HIGH  = 5;
   localparam int ST_INTEG = 6;
   localparam int ST_BAT   = 7;
   // ********************************
   // lcd drive levels, thirds of the drive voltage
   // ********************************
   localparam logic [1:0] LVL_V0 = 2'h0;
   localparam logic [1:0] LVL_V1 = 2'h1;
   localparam logic [1:0] LVL_V2 = 2'h2;
   localparam logic [1:0] LVL_V3 = 2'h3;
endpackage : mlcd_pkg

// File: rtl/mlcd_divider.sv
// step-counting divider giving a one-cycle tick every DIV steps
`timescale 1ns/1ps
`default_nettype none
module mlcd_divider #(
   parameter int DIV = 2
) (
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   input  wire logic i_step,
   output logic      o_tick
);
   localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [W-1:0] LAST = W'(DIV - 1);
   logic [W-1:0] cnt_q;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_q <= '0;
      end else if (i_step) begin
         cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + W'(1);
      end
   end

   assign o_tick = i_step && (cnt_q == LAST);
endmodule : mlcd_divider
`default_nettype wire

// File: rtl/mlcd_seg_drive.sv
// triplex backplane and segment line level generator, 1/3 bias
`timescale 1ns/1ps
`default_nettype none
module mlcd_seg_drive
   import mlcd_pkg::*;
#(
   parameter int N = LINES
) (
   input  wire logic           i_clk,
   input  wire logic           i_reset_n,
   input  wire logic [1:0]     i_slot,
   input  wire logic           i_pos,
   input  wire logic [3*N-1:0] i_seg,
   output logic      [5:0]     o_bp,
   output logic      [2*N-1:0] o_line
);
   // negative half mirrors the levels so the glass sees no dc
   function automatic logic [1:0] mirror(input logic [1:0] v,
                                         input logic       pos);
      mirror = pos ? v : LVL_V3 - v;
   endfunction : mirror

   genvar b, l;
   generate
      for (b = 0; b < 3; b++) begin : g_bp
         always_ff @(posedge i_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               o_bp[2*b +: 2] <= LVL_V0;
            end else begin
               o_bp[2*b +: 2] <= mirror((i_slot == 2'(b)) ? LVL_V3 : LVL_V1,
                                        i_pos);
            end
         end
      end
      for (l = 0; l < N; l++) begin : g_line
         always_ff @(posedge i_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               o_line[2*l +: 2] <= LVL_V0;
            end else begin
               o_line[2*l +: 2] <= mirror(i_seg[3*l + i_slot] ? LVL_V0 : LVL_V2,
                                          i_pos);
            end
         end
      end
   endgenerate
endmodule : mlcd_seg_drive
`default_nettype wire

// File: verif/mlcd_lcd_model.sv
// triplex lcd glass and annunciator wiring model facing the drive block
`timescale 1ns/1ps
`default_nettype none
module mlcd_lcd_model
   import mlcd_pkg::*;
(
   input  wire logic               i_clk,
   input  wire logic               i_reset_n,
   input  wire logic [1:0]         i_bp_first,
   input  wire logic [1:0]         i_bp_second,
   input  wire logic [1:0]         i_bp_third,
   input  wire logic [2*LINES-1:0] i_line,
   input  wire logic               i_ann,
   output logic      [3*LINES-1:0] o_lit,
   output logic                    o_ann_lit,
   output logic                    o_bp_fault
);
   logic [1:0] bp [3];
   logic       live_q;
   int         nsel;
   assign bp[0] = i_bp_first;
   assign bp[1] = i_bp_second;
   assign bp[2] = i_bp_third;
   // a pixel darkens only under full drive across it
   function automatic logic lit(input logic [1:0] b, input logic [1:0] s);
      return (b == LVL_V3 && s == LVL_V0) || (b == LVL_V0 && s == LVL_V3);
   endfunction : lit
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_lit      <= '0;
         o_ann_lit  <= 1'b0;
         o_bp_fault <= 1'b0;
         live_q     <= 1'b0;
      end else begin
         live_q <= 1'b1;
         nsel = 0;
         for (int k = 0; k < 3; k++) begin
            if (bp[k] == LVL_V3 || bp[k] == LVL_V0) begin
               nsel++;
               for (int l = 0; l < LINES; l++) begin
                  o_lit[3*l+k] <= lit(bp[k], i_line[2*l+:2]);
               end
            end
         end
         // lit element wired to the annunciator pin, blank ones to bp
         if (bp[0] == LVL_V3 || bp[0] == LVL_V0) begin
            o_ann_lit <= lit(bp[0], {2{i_ann}});
         end
         // exactly one backplane selected at any time
         if (live_q && nsel != 1) begin
            o_bp_fault <= 1'b1;
         end
      end
   end
endmodule : mlcd_lcd_model
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the meter mode and triplex lcd drive block
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import mlcd_pkg::*;
;
   localparam int OD = 2;
   localparam int GD = 20;
   localparam int CV = 40;
   localparam int IG = 10;
   logic i_clk = 1'b0, rst_n = 1'b0, msel = 1'b0, psel = 1'b0, pls = 1'b0;
   logic lo = 1'b0, hi = 1'b0, pk = 1'b0, bt = 1'b0, rd = 1'b0, wr = 1'b0;
   logic [CW-1:0] conv = '0;
   logic [3:0] addr = '0;
   logic [31:0] wd = '0, rdata;
   logic wreq, ann, buz, cclk, integ, ann_lit, bp_fault;
   logic [1:0] bp_a, bp_b, bp_c;
   logic [2*LINES-1:0] line;
   logic [3*LINES-1:0] lit;
   int err_total = 0, checks_done = 0, half = 0, pcnt = 0;
   int hv[4] = '{2, 4, 5, 10};
   always #25 i_clk = ~i_clk;
   mlcd_top #(.OSC_DIV_P(OD), .GATE_DIV_P(GD), .CONV_P(CV), .INTEG_P(IG))
   DUT (.i_clk(i_clk), .i_reset_n(rst_n), .i_measure_select(msel),
      .i_probe_mode_select(psel), .i_range_or_pulse_input(pls),
      .i_low_probe_input(lo), .i_high_probe_input(hi),
      .i_peak_hold_select(pk), .i_low_battery(bt), .i_conv_data(conv),
      .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
      .o_backplane_first(bp_a), .o_backplane_second(bp_b),
      .o_backplane_third(bp_c), .o_segment_level(line), .o_annunciator(ann),
      .o_buzzer(buz), .o_conv_clk(cclk), .o_integrate_phase(integ));
   mlcd_lcd_model LCD (.i_clk(i_clk), .i_reset_n(rst_n), .i_bp_first(bp_a),
      .i_bp_second(bp_b), .i_bp_third(bp_c), .i_line(line), .i_ann(ann),
      .o_lit(lit), .o_ann_lit(ann_lit), .o_bp_fault(bp_fault));
   // ********************************
   // pulse source, period 2*half clocks
   // ********************************
   always @(posedge i_clk) begin
      if (half == 0) pls <= 1'b0;
      else if (pcnt + 1 >= half) begin
         pcnt <= 0;
         pls <= ~pls;
      end else pcnt <= pcnt + 1;
   end
   // ********************************
   // tasks and expectations
   // ********************************
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run;
      if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : complete_run
   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge i_clk);
      rd <= ~w;
      wr <= w;
      addr <= a;
      wd <= d;
      do begin
         @(posedge i_clk);
         n++;
      end while (wreq !== 1'b0 && n < 100);
      if (wreq !== 1'b0) err_total++;
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic ticks(input int n);
      repeat (n) @(posedge i_clk);
   endtask : ticks
   function automatic logic sig(input int s);
      case (s)
         0: return ann;
         1: return buz;
         2: return cclk;
         default: return integ;
      endcase
   endfunction : sig
   // high time and period in clocks; returns at a falling edge
   task automatic meas(input int s, output int h, output int p);
      int n;
      n = 0;
      @(negedge i_clk);
      while (sig(s) !== 1'b0 && n < 4000) begin @(negedge i_clk); n++; end
      while (sig(s) !== 1'b1 && n < 4000) begin @(negedge i_clk); n++; end
      h = 0;
      p = 0;
      while (sig(s) === 1'b1 && p < 4000) begin @(negedge i_clk); h++; p++; end
      while (sig(s) !== 1'b1 && p < 4000) begin @(negedge i_clk); p++; end
   endtask : meas
   function automatic logic [3*LINES-1:0] exp_lit(input logic [31:0] s,
      input logic [1:0] dp, input logic sg, input logic b, input logic k);
      logic [3*LINES-1:0] r;
      logic [7:0] g;
      r = '0;
      for (int d = 0; d < DIGITS; d++) begin
         g = s[8*d+:8];
         r[9*d+:9] = {g[3], g[2], (d == 1) & k, g[4], g[6], g[1],
                      (d < 3) && (dp == d), g[5], g[0]};
      end
      r[36+:3] = {b, sg, 1'b0};
      return r;
   endfunction : exp_lit
   // ********************************
   // main sequence
   // ********************************
   initial begin
      logic [31:0] q, seg;
      logic [1:0] dp;
      logic sg;
      int h, p, n;
      void'($urandom(89));
      ticks(16);
      rst_n <= 1'b1;
      ticks(2);
      bus(0, REG_CTRL, 0, q); check(q, CTRL_RESET);
      bus(0, REG_SEG, 0, q); check(q, SEG_RESET);
      bus(1, REG_STATUS, 32'hffff_ffff, q);
      bus(0, REG_STATUS, 0, q); check(q & 32'hbf, 0);
      bus(0, 4'h6, 0, q); check(q, 0);
      bus(1, REG_CTRL, 32'hffff_fffe, q);
      bus(0, REG_CTRL, 0, q); check(q, 0);
      meas(0, h, p); check(p, BP_DIV * OD);
      check(h, BP_DIV * OD / 2);
      meas(2, h, p); check(p, CONV_CLK_DIV * OD);
      meas(3, h, p); check(h, IG * OD);
      check(p, CV * OD);
      for (int i = 0; i < 3; i++) begin
         seg = $urandom;
         dp = 2'($urandom);
         sg = 1'($urandom);
         @(posedge i_clk);
         lo <= dp[0];
         hi <= dp[1];
         bt <= sg ^ i[0];
         pk <= i[1];
         conv <= CW'($urandom % 4000);
         bus(1, REG_SEG, seg, q);
         bus(1, REG_CTRL, {31'h0, sg}, q);
         ticks(2 * BP_DIV * OD + 20);
         check(lit, exp_lit(seg, dp, sg, sg ^ i[0], i[1]));
         check(ann_lit, 1);
         check(bp_fault, 0);
         bus(0, REG_STATUS, 0, q);
         check(q & 32'hbf, {sg ^ i[0], 4'h0, i[1], 2'h0});
         meas(0, h, p);
         repeat (20) @(negedge i_clk);
         check({bp_c, bp_b, bp_a}, {LVL_V2, LVL_V2, LVL_V0});
         repeat (80) @(negedge i_clk);
         check({bp_c, bp_b, bp_a}, {LVL_V2, LVL_V0, LVL_V2});
      end
      @(posedge i_clk);
      pk <= 1'b0;
      conv <= CW'(4000 + $urandom % 96);
      ticks(3 * CV * OD);
      bus(0, REG_STATUS, 0, q); check(q[ST_OVER], 1);
      bus(0, REG_READING, 0, q); check(q, conv);
      @(posedge i_clk);
      msel <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         @(posedge i_clk);
         half <= hv[i];
         ticks(6 * GD * OD);
         bus(0, REG_READING, 0, q); check(q, GD * OD / (2 * hv[i]));
      end
      @(posedge i_clk);
      pk <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         @(posedge i_clk);
         // counts 5, then 10, then 4 which must not replace the held 10
         half <= hv[i == 2 ? 2 : 1 - i];
         ticks(6 * GD * OD);
         bus(0, REG_READING, 0, q); check(q, i == 0 ? 5 : 10);
      end
      bus(0, REG_STATUS, 0, q); check(q[ST_PEAK:ST_FREQ], 3'b101);
      @(posedge i_clk);
      pk <= 1'b0;
      ticks(6 * GD * OD);
      bus(0, REG_READING, 0, q); check(q, 4);
      @(posedge i_clk);
      psel <= 1'b1;
      half <= 0;
      for (int i = 0; i < 4; i++) begin
         @(posedge i_clk);
         lo <= i[0];
         hi <= i[1];
         ticks(12);
         bus(0, REG_STATUS, 0, q); check(q[ST_HIGH:ST_LOW], i[1:0]);
         if (i[0]) begin
            meas(1, h, p); check(p, TONE_DIV * OD);
         end else begin
            n = 0;
            repeat (40) begin
               @(negedge i_clk);
               if (buz !== 1'b0) n++;
            end
            check(n, 0);
         end
      end
      ticks(2 * BP_DIV * OD + 20);
      check({lit[33], lit[36]}, 2'b11);
      complete_run();
   end
   // hang guard, well past the expected run length
   initial begin
      ticks(60000);
      err_total++;
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
